// [core/cdcfg_top.sv]
// clock configuration registers, serial access port and clock selection
//
// Operation
// - a set bypass bit sends the reference clock around the loop instead of through it.
// - bypass never powers the loop down; the loop power-down follows only its own request.
// - the converter clock comes from the receive reference normally and from the loop clock in alternate timing.
// - the converter-halve bit resets low and, when set, halves the selected converter clock.
// - the alternate timing bit resets low so the reference drives the receive path, and when set the loop clock does.
// - the loop clock drives the transmit path undivided unless the fifth-divide bit is set, which divides it by 5.
// - the multiply field resets to 000 and codes 000..100 give 1x,2x,4x,8x,16x while 101..111 are unused.
// - the loop output rate is the reference times the multiply factor, optionally divided by five.
// - with the aux bit set the second interface clock pin carries the loop clock, only when enabled or in full duplex.
// - the slow-loop bit is forwarded to the loop to change its bandwidth.
// - both registers are read and written through the serial port in one- or two-byte transfers.
// - instruction and data bits move most significant or least significant first as configured.
// - read data leaves on the bidirectional data pin or on the separate output pin as configured.
// - writes commit only after the 16th rising serial edge, or the 24th for two bytes, and aborted writes are dropped.
`timescale 1ns/100ps
`default_nettype none
module cdcfg_top (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       sen_n_i,
    input  wire logic       sclk_i,
    input  wire logic       sdio_i,
    output logic            sdio_o,
    output logic            sdio_oe_o,
    output logic            serial_data_out_pin_o,
    output logic            serial_data_out_pin_oe_o,
    input  wire logic       lsb_first_i,
    input  wire logic       sdio_bidir_i,
    input  wire logic       rx_reference_clock_in_i,
    input  wire logic       loop_out_tick_i,
    input  wire logic       loop_pd_req_i,
    input  wire logic       iface_b12_i,
    input  wire logic       full_duplex_i,
    input  wire logic       iface_default_i,
    output logic            loop_bypass_o,
    output logic            loop_power_down_o,
    output logic [4:0]      loop_mult_factor_o,
    output logic            loop_fifth_divide_o,
    output logic            loop_slow_o,
    output logic            rx_path_alt_o,
    output logic            adc_clk_tick_o,
    output logic            tx_clk_tick_o,
    output logic            second_interface_clock_pin_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_raw;
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic [3:0] prev_ff;

    assign pin_raw = {rx_reference_clock_in_i, sdio_i, sclk_i, sen_n_i};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    sync1_ff[gi] <= 1'b1;
                    sync2_ff[gi] <= 1'b1;
                    prev_ff[gi]  <= 1'b1;
                end else if (ce_i) begin
                    sync1_ff[gi] <= pin_raw[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                    prev_ff[gi]  <= sync2_ff[gi];
                end
            end
        end
    endgenerate

    logic sel_act;
    logic sclk_rise;
    logic sclk_fall;
    logic din;
    logic ref_tick;

    assign sel_act   = !sync2_ff[0];
    assign sclk_rise = sync2_ff[1] && !prev_ff[1];
    assign sclk_fall = !sync2_ff[1] && prev_ff[1];
    assign din       = sync2_ff[2];
    assign ref_tick  = sync2_ff[3] && !prev_ff[3];

    // ------------------------------------------------------------
    // serial port and registers
    // ------------------------------------------------------------
    logic [7:0] src_ff,     nxt_src;
    logic [7:0] route_ff,   nxt_route;
    logic [4:0] cnt_ff,     nxt_cnt;
    logic [7:0] in_ff,      nxt_in;
    logic [7:0] inst_ff,    nxt_inst;
    logic [7:0] first_ff,   nxt_first;
    logic [7:0] out_ff,     nxt_out;
    logic       bit_ff,     nxt_bit;
    logic       drive_ff,   nxt_drive;
    logic       oe_bi_ff,   nxt_oe_bi;
    logic       oe_uni_ff,  nxt_oe_uni;
    logic [7:0] shifted;
    logic [5:0] addr_now;
    logic [5:0] addr_two;
    logic       is_read;
    logic       is_two;

    function automatic logic [7:0] rd_val(input logic [5:0] a, input logic [7:0] s, input logic [7:0] r);
        // other addresses belong to neighbouring blocks and read zero here
        if (a == cdcfg_pkg::ADDR_CLK_SRC)
            return s & cdcfg_pkg::MASK_CLK_SRC;
        else if (a == cdcfg_pkg::ADDR_CLK_ROUTE)
            return r & cdcfg_pkg::MASK_CLK_ROUTE;
        return 8'h00;
    endfunction

    always_comb begin
        shifted   = lsb_first_i ? {din, in_ff[7:1]} : {in_ff[6:0], din};
        is_read   = inst_ff[cdcfg_pkg::BIT_INST_RD];
        is_two    = inst_ff[cdcfg_pkg::BIT_INST_TWO];
        addr_now  = inst_ff[5:0];
        addr_two  = lsb_first_i ? addr_now + 6'h01 : addr_now - 6'h01;
        nxt_src   = src_ff;
        nxt_route = route_ff;
        nxt_cnt   = cnt_ff;
        nxt_in    = in_ff;
        nxt_inst  = inst_ff;
        nxt_first = first_ff;
        nxt_out   = out_ff;
        nxt_bit   = bit_ff;
        nxt_drive = drive_ff;
        if (!sel_act) begin
            // deselect drops any partial frame, pending first byte included
            nxt_cnt   = 5'h00;
            nxt_drive = 1'b0;
        end else if (sclk_rise && cnt_ff < cdcfg_pkg::EDGES_TWO) begin
            nxt_cnt = cnt_ff + 5'h01;
            nxt_in  = shifted;
            if (nxt_cnt == cdcfg_pkg::EDGES_INST) begin
                nxt_inst = shifted;
                nxt_out  = rd_val(shifted[5:0], src_ff, route_ff);
            end else if (nxt_cnt == cdcfg_pkg::EDGES_ONE) begin
                nxt_first = shifted;
                nxt_out   = rd_val(addr_two, src_ff, route_ff);
                if (!is_read && !is_two) begin
                    if (addr_now == cdcfg_pkg::ADDR_CLK_SRC)
                        nxt_src = shifted & cdcfg_pkg::MASK_CLK_SRC;
                    if (addr_now == cdcfg_pkg::ADDR_CLK_ROUTE)
                        nxt_route = shifted & cdcfg_pkg::MASK_CLK_ROUTE;
                end
            end else if (nxt_cnt == cdcfg_pkg::EDGES_TWO && !is_read && is_two) begin
                if (addr_now == cdcfg_pkg::ADDR_CLK_SRC)   nxt_src   = first_ff & cdcfg_pkg::MASK_CLK_SRC;
                if (addr_now == cdcfg_pkg::ADDR_CLK_ROUTE) nxt_route = first_ff & cdcfg_pkg::MASK_CLK_ROUTE;
                if (addr_two == cdcfg_pkg::ADDR_CLK_SRC)   nxt_src   = shifted & cdcfg_pkg::MASK_CLK_SRC;
                if (addr_two == cdcfg_pkg::ADDR_CLK_ROUTE) nxt_route = shifted & cdcfg_pkg::MASK_CLK_ROUTE;
            end
        end else if (sclk_fall && cnt_ff >= cdcfg_pkg::EDGES_INST && is_read) begin
            // read bits leave on falling edges; a two-byte read runs on into the second byte
            if ((cnt_ff == cdcfg_pkg::EDGES_TWO) || (!is_two && cnt_ff >= cdcfg_pkg::EDGES_ONE)) begin
                nxt_drive = 1'b0;
            end else begin
                nxt_drive = 1'b1;
                nxt_bit   = lsb_first_i ? out_ff[0] : out_ff[7];
                nxt_out   = lsb_first_i ? {1'b0, out_ff[7:1]} : {out_ff[6:0], 1'b0};
            end
        end
        // enables are registered so a mode change never glitches a pad driver
        nxt_oe_bi  = nxt_drive && sdio_bidir_i;
        nxt_oe_uni = nxt_drive && !sdio_bidir_i;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            src_ff   <= cdcfg_pkg::RST_CLK_SRC;
            route_ff <= cdcfg_pkg::RST_CLK_ROUTE;
            cnt_ff   <= 5'h00;
            in_ff    <= 8'h00;
            inst_ff  <= 8'h00;
            first_ff <= 8'h00;
            out_ff   <= 8'h00;
            bit_ff   <= 1'b0;
            drive_ff <= 1'b0;
            oe_bi_ff  <= 1'b0;
            oe_uni_ff <= 1'b0;
        end else if (ce_i) begin
            src_ff   <= nxt_src;
            route_ff <= nxt_route;
            cnt_ff   <= nxt_cnt;
            in_ff    <= nxt_in;
            inst_ff  <= nxt_inst;
            first_ff <= nxt_first;
            out_ff   <= nxt_out;
            bit_ff   <= nxt_bit;
            drive_ff <= nxt_drive;
            oe_bi_ff  <= nxt_oe_bi;
            oe_uni_ff <= nxt_oe_uni;
        end
    end

    // ------------------------------------------------------------
    // clock selection and division
    // ------------------------------------------------------------
    logic loop_tick;
    logic adc_tick;
    logic tx_tick;

    assign loop_tick = src_ff[cdcfg_pkg::BIT_BYPASS] ? ref_tick : loop_out_tick_i;

    cdcfg_tick_div u_adc_div (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .ce_i     (ce_i),
        .tick_a_i (ref_tick),
        .tick_b_i (loop_tick),
        .sel_b_i  (src_ff[cdcfg_pkg::BIT_ALT_TIME]),
        .ratio_i  (src_ff[cdcfg_pkg::BIT_ADC_HALF] ? cdcfg_pkg::RATIO_ADC : cdcfg_pkg::RATIO_ONE),
        .tick_o   (adc_tick)
    );

    cdcfg_tick_div u_tx_div (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .ce_i     (ce_i),
        .tick_a_i (loop_tick),
        .tick_b_i (loop_tick),
        .sel_b_i  (1'b0),
        .ratio_i  (src_ff[cdcfg_pkg::BIT_FIFTH] ? cdcfg_pkg::RATIO_TX : cdcfg_pkg::RATIO_ONE),
        .tick_o   (tx_tick)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [4:0] factor;
    logic       aux_ok;
    logic       aux_ff;
    logic [4:0] fac_ff;
    logic [4:0] ctl_ff;

    always_comb begin
        // unused codes hold the loop at 1x rather than an undefined factor
        if (src_ff[cdcfg_pkg::BIT_MULT_HI:0] <= cdcfg_pkg::MULT_MAX_CODE)
            factor = 5'h01 << src_ff[cdcfg_pkg::BIT_MULT_HI:0];
        else
            factor = 5'h01;
        aux_ok = route_ff[cdcfg_pkg::BIT_AUX_LOOP] && (iface_b12_i || full_duplex_i);
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            aux_ff <= 1'b0;
            fac_ff <= 5'h01;
            ctl_ff <= 5'h00;
        end else if (ce_i) begin
            aux_ff <= aux_ok ? loop_tick : iface_default_i;
            fac_ff <= factor;
            ctl_ff <= {src_ff[cdcfg_pkg::BIT_BYPASS],
                       loop_pd_req_i,
                       src_ff[cdcfg_pkg::BIT_FIFTH],
                       route_ff[cdcfg_pkg::BIT_SLOW],
                       src_ff[cdcfg_pkg::BIT_ALT_TIME]};
        end
    end

    assign loop_bypass_o                = ctl_ff[4];
    assign loop_power_down_o            = ctl_ff[3];
    assign loop_fifth_divide_o          = ctl_ff[2];
    assign loop_slow_o                  = ctl_ff[1];
    assign rx_path_alt_o                = ctl_ff[0];
    assign loop_mult_factor_o           = fac_ff;
    assign adc_clk_tick_o               = adc_tick;
    assign tx_clk_tick_o                = tx_tick;
    assign second_interface_clock_pin_o = aux_ff;
    assign sdio_o                       = bit_ff;
    assign serial_data_out_pin_o        = bit_ff;
    assign sdio_oe_o                    = oe_bi_ff;
    assign serial_data_out_pin_oe_o     = oe_uni_ff;
endmodule // cdcfg_top
`default_nettype wire

// [inc/cdcfg_pkg.sv]
// constants shared by the clock distribution configuration block
package cdcfg_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_CLK_SRC   = 6'h15;
    localparam logic [5:0] ADDR_CLK_ROUTE = 6'h16;
    localparam logic [7:0] RST_CLK_SRC    = 8'h00;
    localparam logic [7:0] RST_CLK_ROUTE  = 8'h00;
    localparam logic [7:0] MASK_CLK_SRC   = 8'hBF;
    localparam logic [7:0] MASK_CLK_ROUTE = 8'h24;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_BYPASS   = 7;
    localparam int BIT_ADC_HALF = 5;
    localparam int BIT_ALT_TIME = 4;
    localparam int BIT_FIFTH    = 3;
    localparam int BIT_MULT_HI  = 2;
    localparam int BIT_AUX_LOOP = 5;
    localparam int BIT_SLOW     = 2;
    localparam int BIT_INST_RD  = 7;
    localparam int BIT_INST_TWO = 6;
    // ------------------------------------------------------------
    // multiply codes and divide ratios
    // ------------------------------------------------------------
    localparam logic [2:0] MULT_MAX_CODE = 3'h4;
    localparam logic [2:0] RATIO_ONE     = 3'h1;
    localparam logic [2:0] RATIO_ADC     = 3'h2;
    localparam logic [2:0] RATIO_TX      = 3'h5;
    // ------------------------------------------------------------
    // serial frame edge counts
    // ------------------------------------------------------------
    localparam logic [4:0] EDGES_INST = 5'h08;
    localparam logic [4:0] EDGES_ONE  = 5'h10;
    localparam logic [4:0] EDGES_TWO  = 5'h18;
endpackage

// [core/cdcfg_tick_div.sv]
// clock-enable divider with boundary-only source and ratio switching
`timescale 1ns/100ps
`default_nettype none
module cdcfg_tick_div (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       tick_a_i,
    input  wire logic       tick_b_i,
    input  wire logic       sel_b_i,
    input  wire logic [2:0] ratio_i,
    output logic            tick_o
);
    logic       sel_ff;
    logic [2:0] ratio_ff;
    logic [2:0] cnt_ff;
    logic       tick_ff;
    logic       nxt_sel;
    logic [2:0] nxt_ratio;
    logic [2:0] nxt_cnt;
    logic       nxt_tick;
    logic       src;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    // source and ratio change only at an output boundary, so no period is cut short
    always_comb begin
        src       = sel_ff ? tick_b_i : tick_a_i;
        nxt_sel   = sel_ff;
        nxt_ratio = ratio_ff;
        nxt_cnt   = cnt_ff;
        nxt_tick  = 1'b0;
        if (src) begin
            if (cnt_ff >= ratio_ff - 3'h1) begin
                nxt_tick  = 1'b1;
                nxt_cnt   = 3'h0;
                nxt_sel   = sel_b_i;
                nxt_ratio = ratio_i;
            end else begin
                nxt_cnt = cnt_ff + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sel_ff   <= 1'b0;
            ratio_ff <= cdcfg_pkg::RATIO_ONE;
            cnt_ff   <= 3'h0;
            tick_ff  <= 1'b0;
        end else if (ce_i) begin
            sel_ff   <= nxt_sel;
            ratio_ff <= nxt_ratio;
            cnt_ff   <= nxt_cnt;
            tick_ff  <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;
endmodule // cdcfg_tick_div
`default_nettype wire

// [dv/cdcfg_chk.sv]
// port-level assertions for the clock configuration block
`timescale 1ns/100ps
`default_nettype none
module cdcfg_chk (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       sen_n_i,
    input wire logic       sdio_bidir_i,
    input wire logic       loop_pd_req_i,
    input wire logic       iface_b12_i,
    input wire logic       full_duplex_i,
    input wire logic       iface_default_i,
    input wire logic       sdio_oe_o,
    input wire logic       serial_data_out_pin_oe_o,
    input wire logic       loop_bypass_o,
    input wire logic       loop_power_down_o,
    input wire logic [4:0] loop_mult_factor_o,
    input wire logic       loop_fifth_divide_o,
    input wire logic       loop_slow_o,
    input wire logic       rx_path_alt_o,
    input wire logic       tx_clk_tick_o,
    input wire logic       second_interface_clock_pin_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------
    // loop control and aux pin
    // ------------------------------------------------------------
    a_pd_follow: assert property ($past(nrst_i) |-> loop_power_down_o == $past(loop_pd_req_i))
        else $error("loop power-down does not follow its request");
    a_aux_default: assert property ($past(nrst_i) && !$past(iface_b12_i) && !$past(full_duplex_i)
        |-> second_interface_clock_pin_o == $past(iface_default_i))
        else $error("aux pin left its default while not enabled");
    a_mult_onehot: assert property ($onehot(loop_mult_factor_o))
        else $error("multiply factor is not a single power of two");
    // the divider latches its ratio at an output tick, so a held divide-by-5 spaces ticks by five
    a_tx_fifth_gap: assert property (tx_clk_tick_o && loop_fifth_divide_o && $past(loop_fifth_divide_o)
        |=> !tx_clk_tick_o [*4])
        else $error("transmit tick too soon while dividing by five");
    // settings only move inside a frame, never while deselected
    a_cfg_quiet: assert property (sen_n_i [*8] |=>
        $stable({loop_bypass_o, loop_mult_factor_o, loop_fifth_divide_o, loop_slow_o, rx_path_alt_o}))
        else $error("clock settings changed outside a serial frame");
    // ------------------------------------------------------------
    // serial output enables
    // ------------------------------------------------------------
    a_oe_bidir: assert property (sdio_oe_o |-> $past(sdio_bidir_i))
        else $error("data pin driven in four-wire mode");
    a_oe_sdo: assert property (serial_data_out_pin_oe_o |-> !$past(sdio_bidir_i))
        else $error("output pin driven in three-wire mode");
    a_oe_idle: assert property (sen_n_i [*6] |-> !sdio_oe_o && !serial_data_out_pin_oe_o)
        else $error("serial pin driven while deselected");
    c_fifth_tick: cover property (tx_clk_tick_o && loop_fifth_divide_o);
    c_bidir_read: cover property (sdio_oe_o);
    c_sdo_read: cover property (serial_data_out_pin_oe_o);
endmodule // cdcfg_chk
bind cdcfg_top cdcfg_chk cdcfg_chk_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .sen_n_i(sen_n_i), .sdio_bidir_i(sdio_bidir_i),
    .loop_pd_req_i(loop_pd_req_i), .iface_b12_i(iface_b12_i), .full_duplex_i(full_duplex_i),
    .iface_default_i(iface_default_i), .sdio_oe_o(sdio_oe_o), .serial_data_out_pin_oe_o(serial_data_out_pin_oe_o),
    .loop_bypass_o(loop_bypass_o), .loop_power_down_o(loop_power_down_o), .loop_mult_factor_o(loop_mult_factor_o),
    .loop_fifth_divide_o(loop_fifth_divide_o), .loop_slow_o(loop_slow_o), .rx_path_alt_o(rx_path_alt_o),
    .tx_clk_tick_o(tx_clk_tick_o), .second_interface_clock_pin_o(second_interface_clock_pin_o));
`default_nettype wire

// [dv/cdcfg_host.sv]
// host-side serial configuration master model
`timescale 1ns/100ps
`default_nettype none
module cdcfg_host (
    input  wire logic clk_i,
    input  wire logic lsb_first_i,
    input  wire logic bidir_i,
    input  wire logic dut_sdio_i,
    input  wire logic dut_sdio_oe_i,
    input  wire logic sdo_i,
    input  wire logic sdo_oe_i,
    output logic      sen_n_o,
    output logic      sclk_o,
    output logic      sdio_o
);
    logic hdrv;
    logic rlast;
    assign sdio_o = dut_sdio_oe_i ? dut_sdio_i : hdrv;
    initial begin
        sen_n_o = 1'b1;
        sclk_o  = 1'b1; // serial clock stands still between frames
        hdrv    = 1'b0;
        rlast   = 1'b0;
    end
    // cut below the frame length aborts the frame after that many rising edges
    task automatic xfer(input logic [7:0] inst, input logic [15:0] wd, input int nb, input int cut,
                        output logic [15:0] rd);
        int n;
        int k;
        int p;
        logic [7:0] b;
        n  = (cut < 8 + 8 * nb) ? cut : 8 + 8 * nb;
        rd = 16'h0000;
        @(negedge clk_i) sen_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            k = i / 8;
            p = lsb_first_i ? i % 8 : 7 - i % 8;
            b = (k == 0) ? inst : (k == 1) ? wd[15:8] : wd[7:0];
            sclk_o = 1'b0;
            // a released line toggles so stale data can never pass for read data
            hdrv = (k > 0 && inst[7]) ? ~hdrv : b[p];
            repeat (5) @(negedge clk_i);
            if (k > 0 && inst[7]) begin
                rlast = bidir_i ? (dut_sdio_oe_i ? dut_sdio_i : ~rlast) : (sdo_oe_i ? sdo_i : ~rlast);
                rd[(2 - k) * 8 + p] = rlast;
            end
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
        end
        repeat (4) @(negedge clk_i);
        sen_n_o = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask
endmodule // cdcfg_host
`default_nettype wire

// [dv/tb_clock_distribution_config.sv]
// self-checking bench for the clock configuration block
`timescale 1ns/100ps
`default_nettype none
module tb_clock_distribution_config;
    logic        clk_i, nrst_i, sen_n, sclk, sdio_w, lsb, bidir, ref_clk, ref_prev, loop_tick, pd_req, b12, fdx, idef;
    logic        sdio_q, sdio_oe, serial_data_out_pin, sdo_oe, byp, fifth, slow, alt, adc_t, tx_t, aux;
    logic [4:0]  mult;
    logic [7:0]  d;
    logic [5:0]  a, a2;
    logic [15:0] rd;
    logic [31:0] st_a, st_b;
    int          error_cnt, total_checks, c_ref, c_loop, c_adc, c_tx, c_aux, ls;
    cdcfg_top cdcfg_top_i (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .sen_n_i(sen_n), .sclk_i(sclk), .sdio_i(sdio_w),
        .sdio_o(sdio_q), .sdio_oe_o(sdio_oe), .serial_data_out_pin_o(serial_data_out_pin), .serial_data_out_pin_oe_o(sdo_oe),
        .lsb_first_i(lsb), .sdio_bidir_i(bidir), .rx_reference_clock_in_i(ref_clk), .loop_out_tick_i(loop_tick),
        .loop_pd_req_i(pd_req), .iface_b12_i(b12), .full_duplex_i(fdx), .iface_default_i(idef),
        .loop_bypass_o(byp), .loop_power_down_o(), .loop_mult_factor_o(mult), .loop_fifth_divide_o(fifth),
        .loop_slow_o(slow), .rx_path_alt_o(alt), .adc_clk_tick_o(adc_t), .tx_clk_tick_o(tx_t),
        .second_interface_clock_pin_o(aux));
    cdcfg_host cdcfg_host_i (.clk_i(clk_i), .lsb_first_i(lsb), .bidir_i(bidir), .dut_sdio_i(sdio_q),
        .dut_sdio_oe_i(sdio_oe), .sdo_i(serial_data_out_pin), .sdo_oe_i(sdo_oe), .sen_n_o(sen_n), .sclk_o(sclk), .sdio_o(sdio_w));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] msk(input logic [5:0] ad, input logic [7:0] v);
        return (ad == cdcfg_pkg::ADDR_CLK_SRC) ? v & cdcfg_pkg::MASK_CLK_SRC :
               (ad == cdcfg_pkg::ADDR_CLK_ROUTE) ? v & cdcfg_pkg::MASK_CLK_ROUTE : 8'h00;
    endfunction
    function automatic logic [7:0] fac(input logic [2:0] c);
        return (c <= 3'h4) ? 8'h01 << c : 8'h01;
    endfunction
    task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask
    // tick counts may differ by the divider phase at either end of the window
    task automatic near(input string nm, input int exp, input int got);
        total_checks++;
        if (got < exp - 2 || got > exp + 2) begin
            error_cnt++;
            $display("unexpected %s: expected %0d, seen %0d", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] ad, input logic [15:0] v, input int nb, input int cut);
        cdcfg_host_i.xfer({1'b0, nb == 2, ad}, v, nb, cut, rd);
    endtask
    task automatic rdreg(input logic [5:0] ad, input int nb);
        cdcfg_host_i.xfer({1'b1, nb == 2, ad}, 16'h0000, nb, 99, rd);
    endtask
    task automatic measure();
        repeat (20) @(negedge clk_i);
        {c_ref, c_loop, c_adc, c_tx, c_aux} = '0;
        repeat (600) @(negedge clk_i);
    endtask
    task automatic wrap_up();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, free-running stimulus and tick counters
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(negedge clk_i) begin
        st_b = xs(st_b);
        loop_tick = st_b[0];
        pd_req = st_b[9];
        idef = st_b[5];
        if (st_b[12:11] == 2'b00) ref_clk = ~ref_clk;
    end
    always @(posedge clk_i) begin
        c_ref += (ref_clk && !ref_prev);
        ref_prev = ref_clk;
        c_loop += loop_tick;
        c_adc += adc_t;
        c_tx += tx_t;
        c_aux += aux;
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        error_cnt++;
        $display("unexpected run length: expected end, seen limit");
        wrap_up();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        st_a = 32'h27;
        st_b = 32'h27;
        {nrst_i, lsb, bidir, ref_clk, ref_prev, loop_tick, pd_req, b12, fdx, idef} = '0;
        {error_cnt, total_checks, c_ref, c_loop, c_adc, c_tx, c_aux} = '0;
        repeat (20) @(negedge clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        for (int r = 21; r < 23; r++) begin
            rdreg(r[5:0], 1);
            chk8("reset value", 8'h00, rd[15:8]);
        end
        chk8("multiply factor", 8'h01, {3'h0, mult});
        for (int c = 0; c < 8; c++) begin
            st_a = xs(st_a);
            lsb = st_a[0];
            bidir = st_a[1];
            d = {st_a[15:11], c[2:0]};
            wr(cdcfg_pkg::ADDR_CLK_SRC, {d, 8'h00}, 1, 99);
            rdreg(cdcfg_pkg::ADDR_CLK_SRC, 1);
            chk8("source register", msk(cdcfg_pkg::ADDR_CLK_SRC, d), rd[15:8]);
            chk8("multiply factor", fac(c[2:0]), {3'h0, mult});
            chk8("bypass fifth alt", {5'h0, d[7], d[3], d[4]}, {5'h0, byp, fifth, alt});
        end
        for (int l = 0; l < 2; l++) begin
            st_a = xs(st_a);
            lsb = l[0];
            a = l[0] ? cdcfg_pkg::ADDR_CLK_SRC : cdcfg_pkg::ADDR_CLK_ROUTE;
            a2 = l[0] ? cdcfg_pkg::ADDR_CLK_ROUTE : cdcfg_pkg::ADDR_CLK_SRC;
            wr(a, st_a[15:0], 2, 99);
            rdreg(a, 2);
            chk8("first byte", msk(a, st_a[15:8]), rd[15:8]);
            chk8("second byte", msk(a2, st_a[7:0]), rd[7:0]);
            wr(a, ~st_a[15:0], 2, 23);
            wr(a, ~st_a[15:0], 1, 15);
            rdreg(a, 2);
            chk8("first byte after abort", msk(a, st_a[15:8]), rd[15:8]);
            chk8("second byte after abort", msk(a2, st_a[7:0]), rd[7:0]);
        end
        wr(6'h20, 16'hFF00, 1, 99);
        rdreg(6'h20, 1);
        chk8("unmapped read", 8'h00, rd[15:8]);
        lsb = 1'b0;
        for (int m = 0; m < 16; m++) begin
            st_a = xs(st_a);
            b12 = st_a[0];
            fdx = st_a[1];
            wr(cdcfg_pkg::ADDR_CLK_SRC, {m[3], 1'b0, m[2:0], 3'h1, 8'h00}, 1, 99);
            wr(cdcfg_pkg::ADDR_CLK_ROUTE, {2'b00, 1'b1, 2'b00, st_a[2], 2'b00, 8'h00}, 1, 99);
            measure();
            ls = m[3] ? c_ref : c_loop;
            near("transmit ticks", m[0] ? ls / 5 : ls, c_tx);
            near("converter ticks", (m[1] ? ls : c_ref) / (m[2] ? 2 : 1), c_adc);
            if (b12 || fdx) near("aux pin ticks", ls, c_aux);
            chk8("slow loop", {7'h0, st_a[2]}, {7'h0, slow});
        end
        wrap_up();
    end
endmodule // tb_clock_distribution_config
`default_nettype wire
